//--- verilog/eag_unit.v
// effective address generation and operand formatting for the core
`timescale 1ns/100ps
`default_nettype none
`include "eag_consts.vh"

module eag_unit (
  input wire clock,
  input wire reset,
  input wire clock_en,
  // request from the decoder, one-cycle pulse
  input wire req_valid,
  input wire [3:0] mode,
  input wire [1:0] op_size,
  input wire [2:0] reg_num,
  input wire [31:0] address_reg_k,
  input wire [31:0] data_reg_k,
  input wire [31:0] index_reg,
  input wire index_long,
  input wire [15:0] ext_word0,
  input wire [15:0] ext_word1,
  input wire [31:0] pc_value,
  input wire [7:0] quick_data,
  input wire [2:0] implied_sel,
  input wire [15:0] status_reg,
  input wire [31:0] user_stack_ptr,
  input wire [31:0] supervisor_stack_ptr,
  input wire [31:0] vector_base,
  input wire [2:0] source_function_code,
  input wire [2:0] dest_function_code,
  input wire bcd_packed,
  input wire [7:0] bcd_byte,
  // results, registered
  output reg done,
  output reg [31:0] effective_address,
  output reg mem_access,
  output reg [31:0] operand,
  output reg operand_valid,
  output reg areg_write,
  output reg [31:0] areg_new,
  output reg [1:0] ext_words_used,
  output reg [5:0] op_width,
  output reg [7:0] bcd_digits,
  output reg bcd_error
);

  // ****************************************************************
  // helpers
  // ****************************************************************

  function [31:0] sext16;
    input [15:0] v;
    begin
      sext16 = {{16{v[15]}}, v};
    end
  endfunction

  function [31:0] sext8;
    input [7:0] v;
    begin
      sext8 = {{24{v[7]}}, v};
    end
  endfunction

  // index value, word form sign-extended
  function [31:0] idx_val;
    input [31:0] v;
    input lng;
    begin
      idx_val = lng ? v : sext16(v[15:0]);
    end
  endfunction

  // base plus index plus short displacement, shared by both indexed modes
  function [31:0] index_ea;
    input [31:0] base;
    input [31:0] idx;
    input lng;
    input [7:0] disp;
    begin
      index_ea = base + idx_val(idx, lng) + sext8(disp);
    end
  endfunction

  // a nibble above nine is not a decimal digit
  function bcd_bad;
    input [3:0] nib;
    begin
      bcd_bad = nib > `EAG_BCD_MAX;
    end
  endfunction

  // byte steps through the stack pointer are doubled so the stack stays word aligned
  function [31:0] step_bytes;
    input [1:0] size;
    input [2:0] rnum;
    begin
      case (size)
        `EAG_SZ_BYTE: step_bytes = (rnum == `EAG_SP_NUM) ? 32'h0000_0002 : 32'h0000_0001;
        `EAG_SZ_WORD: step_bytes = 32'h0000_0002;
        `EAG_SZ_LONG: step_bytes = 32'h0000_0004;
        default: step_bytes = 32'h0000_0001;
      endcase
    end
  endfunction

  // ****************************************************************
  // address arithmetic
  // ****************************************************************

  reg [31:0] step;
  reg [31:0] ea_nxt;
  reg mem_nxt;
  reg [31:0] opnd_nxt;
  reg opv_nxt;
  reg aw_nxt;
  reg [31:0] an_nxt;
  reg [1:0] ext_nxt;
  reg [5:0] width_nxt;
  reg [7:0] bcd_nxt;
  reg bcd_err_nxt;

  // the subtractor serves both the address and the write-back value, the adder only the write-back value
  wire [31:0] inc_addr;
  wire [31:0] dec_addr;
  assign inc_addr = address_reg_k + step;
  assign dec_addr = address_reg_k - step;

  // operand step in bytes
  always @* begin
    step = step_bytes(op_size, reg_num);
  end

  // operand width in bits
  always @* begin
    case (op_size)
      `EAG_SZ_BYTE: width_nxt = `EAG_W_BYTE;
      `EAG_SZ_WORD: width_nxt = `EAG_W_WORD;
      `EAG_SZ_LONG: width_nxt = `EAG_W_LONG;
      default: width_nxt = `EAG_W_BIT;
    endcase
  end

  // bcd unpacking: packed gives two digits, unpacked only the low nibble
  always @* begin
    if (bcd_packed == `EAG_BCD_PACKED) begin
      bcd_nxt = bcd_byte;
      bcd_err_nxt = bcd_bad(bcd_byte[7:4]) || bcd_bad(bcd_byte[3:0]);
    end else begin
      bcd_nxt = {4'h0, bcd_byte[3:0]};
      bcd_err_nxt = bcd_bad(bcd_byte[3:0]);
    end
  end

  always @* begin
    ea_nxt = `EAG_RST_ADDR;
    mem_nxt = 1'b1;
    opnd_nxt = `EAG_RST_DATA;
    opv_nxt = 1'b0;
    aw_nxt = 1'b0;
    an_nxt = address_reg_k;
    ext_nxt = 2'h0;
    case (mode)
      `EAG_M_DREG: begin
        mem_nxt = 1'b0;
        opnd_nxt = data_reg_k;
        opv_nxt = 1'b1;
      end
      `EAG_M_AREG: begin
        mem_nxt = 1'b0;
        opnd_nxt = address_reg_k;
        opv_nxt = 1'b1;
      end
      `EAG_M_IND: begin
        ea_nxt = address_reg_k;
      end
      `EAG_M_POSTINC: begin
        ea_nxt = address_reg_k;
        aw_nxt = 1'b1;
        an_nxt = inc_addr;
      end
      `EAG_M_PREDEC: begin
        ea_nxt = dec_addr;
        aw_nxt = 1'b1;
        an_nxt = dec_addr;
      end
      `EAG_M_DISP: begin
        ea_nxt = address_reg_k + sext16(ext_word0);
        ext_nxt = 2'h1;
      end
      `EAG_M_INDEX: begin
        ea_nxt = index_ea(address_reg_k, index_reg, index_long, ext_word0[7:0]);
        ext_nxt = 2'h1;
      end
      `EAG_M_ABS_W: begin
        ea_nxt = sext16(ext_word0);
        ext_nxt = 2'h1;
      end
      `EAG_M_ABS_L: begin
        ea_nxt = {ext_word0, ext_word1};
        ext_nxt = 2'h2;
      end
      `EAG_M_PC_DISP: begin
        ea_nxt = pc_value + sext16(ext_word0);
        ext_nxt = 2'h1;
      end
      `EAG_M_PC_INDEX: begin
        ea_nxt = index_ea(pc_value, index_reg, index_long, ext_word0[7:0]);
        ext_nxt = 2'h1;
      end
      `EAG_M_IMM: begin
        mem_nxt = 1'b0;
        opv_nxt = 1'b1;
        if (op_size == `EAG_SZ_LONG) begin
          opnd_nxt = {ext_word0, ext_word1};
          ext_nxt = 2'h2;
        end else if (op_size == `EAG_SZ_BYTE) begin
          opnd_nxt = {24'h00_0000, ext_word0[7:0]};
          ext_nxt = 2'h1;
        end else begin
          opnd_nxt = {16'h0000, ext_word0};
          ext_nxt = 2'h1;
        end
      end
      `EAG_M_QUICK: begin
        mem_nxt = 1'b0;
        opv_nxt = 1'b1;
        opnd_nxt = sext8(quick_data);
      end
      `EAG_M_IMPLIED: begin
        mem_nxt = 1'b0;
        opv_nxt = 1'b1;
        case (implied_sel)
          `EAG_I_STATUS: opnd_nxt = {16'h0000, status_reg};
          `EAG_I_USP: opnd_nxt = user_stack_ptr;
          `EAG_I_SSP: opnd_nxt = supervisor_stack_ptr;
          `EAG_I_PC: opnd_nxt = pc_value;
          `EAG_I_VBR: opnd_nxt = vector_base;
          `EAG_I_SFC: opnd_nxt = {29'h0, source_function_code};
          `EAG_I_DFC: opnd_nxt = {29'h0, dest_function_code};
          default: opnd_nxt = `EAG_RST_DATA;
        endcase
      end
      default: begin
        mem_nxt = 1'b0;
      end
    endcase
  end

  // ****************************************************************
  // result registers
  // ****************************************************************

  // all results except done and areg_write hold until the next request so the decoder may sample late
  // done and areg_write stretch while clock_en is low, so a stalled decoder
  // still sees them; it must count done only on enabled edges
  always @(posedge clock or posedge reset) begin
    if (reset) begin
      done <= `EAG_RST_FLAG;
      effective_address <= `EAG_RST_ADDR;
      mem_access <= `EAG_RST_FLAG;
      operand <= `EAG_RST_DATA;
      operand_valid <= `EAG_RST_FLAG;
      areg_write <= `EAG_RST_FLAG;
      areg_new <= `EAG_RST_ADDR;
      ext_words_used <= `EAG_RST_EXT;
      op_width <= `EAG_RST_WIDTH;
      bcd_digits <= `EAG_RST_BCD;
      bcd_error <= `EAG_RST_FLAG;
    end else if (clock_en) begin
      done <= req_valid;
      areg_write <= req_valid & aw_nxt;
      if (req_valid) begin
        effective_address <= ea_nxt;
        mem_access <= mem_nxt;
        operand <= opnd_nxt;
        operand_valid <= opv_nxt;
        areg_new <= an_nxt;
        ext_words_used <= ext_nxt;
        op_width <= width_nxt;
        bcd_digits <= bcd_nxt;
        bcd_error <= bcd_err_nxt;
      end
    end
  end

endmodule // eag_unit
`default_nettype wire

//--- verilog/eag_consts.vh
// constants for the effective address generation unit
`ifndef EAG_CONSTS_VH
`define EAG_CONSTS_VH

// operand size codes
`define EAG_SZ_BYTE 2'h0
`define EAG_SZ_WORD 2'h1
`define EAG_SZ_LONG 2'h2
`define EAG_SZ_BIT 2'h3

// operand widths in bits
`define EAG_W_BIT 6'h01
`define EAG_W_BYTE 6'h08
`define EAG_W_WORD 6'h10
`define EAG_W_LONG 6'h20

// addressing mode codes
`define EAG_M_DREG 4'h0
`define EAG_M_AREG 4'h1
`define EAG_M_IND 4'h2
`define EAG_M_POSTINC 4'h3
`define EAG_M_PREDEC 4'h4
`define EAG_M_DISP 4'h5
`define EAG_M_INDEX 4'h6
`define EAG_M_ABS_W 4'h7
`define EAG_M_ABS_L 4'h8
`define EAG_M_PC_DISP 4'h9
`define EAG_M_PC_INDEX 4'ha
`define EAG_M_IMM 4'hb
`define EAG_M_QUICK 4'hc
`define EAG_M_IMPLIED 4'hd

// implied system register selects
`define EAG_I_STATUS 3'h0
`define EAG_I_USP 3'h1
`define EAG_I_SSP 3'h2
`define EAG_I_PC 3'h3
`define EAG_I_VBR 3'h4
`define EAG_I_SFC 3'h5
`define EAG_I_DFC 3'h6

// stack pointer register number
`define EAG_SP_NUM 3'h7

// bcd layout select and largest valid digit
`define EAG_BCD_PACKED 1'b1
`define EAG_BCD_MAX 4'h9

// reset values
`define EAG_RST_ADDR 32'h0000_0000
`define EAG_RST_DATA 32'h0000_0000
`define EAG_RST_FLAG 1'b0
`define EAG_RST_EXT 2'h0
`define EAG_RST_WIDTH 6'h00
`define EAG_RST_BCD 8'h00

`endif

//--- dv/eag_unit_sva.sv
// assertions on the effective address unit ports
`timescale 1ns/100ps
`default_nettype none
module eag_unit_sva (
  input wire clock,
  input wire reset,
  input wire clock_en,
  input wire req_valid,
  input wire [3:0] mode,
  input wire [1:0] op_size,
  input wire [2:0] reg_num,
  input wire [31:0] address_reg_k,
  input wire [15:0] ext_word0,
  input wire [31:0] pc_value,
  input wire done,
  input wire [31:0] effective_address,
  input wire mem_access,
  input wire operand_valid,
  input wire areg_write,
  input wire [31:0] areg_new,
  input wire [5:0] op_width
);
  // ***
  // a taken request is judged one edge later
  // ***
  wire tk = clock_en && req_valid;
  wire [31:0] long_disp = {{16{ext_word0[15]}}, ext_word0};
  default clocking cb @(posedge clock); endclocking
  default disable iff (reset);
  a_reg_direct: assert property (tk && mode < 2 |=> !mem_access && operand_valid) else $error("regdir");
  a_postinc_ea: assert property (tk && mode == 3 |=> areg_write && effective_address == $past(address_reg_k)) else $error("pi");
  a_predec_long: assert property (tk && mode == 4 && op_size == 2 |=> effective_address == $past(address_reg_k) - 4) else $error("pd");
  a_predec_new: assert property (tk && mode == 4 |=> areg_new == effective_address && done) else $error("pdn");
  a_disp_add: assert property (tk && mode == 5 |=> effective_address == $past(address_reg_k) + $past(long_disp)) else $error("disp");
  a_sp_byte: assert property (tk && mode == 3 && op_size == 0 && reg_num == 7 |=> areg_new == effective_address + 2) else $error("sp");
  a_long_width: assert property (tk && op_size == 2 |=> op_width == 32) else $error("width");
  a_pc_disp: assert property (tk && mode == 9 |=> effective_address == $past(pc_value) + $past(long_disp)) else $error("pc");
  cover property (tk && mode == 4);
  cover property (tk && mode == 3 && op_size == 0 && reg_num == 7);
  cover property (tk ##1 tk);
endmodule // eag_unit_sva
bind eag_unit eag_unit_sva chk_u (
  .clock(clock),
  .reset(reset),
  .clock_en(clock_en),
  .req_valid(req_valid),
  .mode(mode),
  .op_size(op_size),
  .reg_num(reg_num),
  .address_reg_k(address_reg_k),
  .ext_word0(ext_word0),
  .pc_value(pc_value),
  .done(done),
  .effective_address(effective_address),
  .mem_access(mem_access),
  .operand_valid(operand_valid),
  .areg_write(areg_write),
  .areg_new(areg_new),
  .op_width(op_width)
);
`default_nettype wire

//--- dv/eag_sysregs.sv
// system register values presented by the decoder side
`timescale 1ns/100ps
`default_nettype none
module eag_sysregs (
  output logic [15:0] status_reg,
  output logic [31:0] user_stack_ptr,
  output logic [31:0] supervisor_stack_ptr,
  output logic [31:0] vector_base,
  output logic [2:0] source_function_code,
  output logic [2:0] dest_function_code
);
  // distinct values so a wrong implied select shows
  assign status_reg = 16'h2715;
  assign user_stack_ptr = 32'h0001_fff0;
  assign supervisor_stack_ptr = 32'h0002_ffe8;
  assign vector_base = 32'h0000_0400;
  assign source_function_code = 3'h5;
  assign dest_function_code = 3'h2;
endmodule // eag_sysregs
`default_nettype wire

//--- dv/eag_unit_test.sv
// self-checking bench for the effective address unit
`timescale 1ns/100ps
`default_nettype none
module eag_unit_test;
  logic clock = 0;
  logic reset = 1;
  logic clock_en = 0, req_valid = 0, index_long = 0, bcd_packed = 0;
  logic [3:0] mode = 0;
  logic [1:0] op_size = 0;
  logic [2:0] reg_num = 0, implied_sel = 0;
  logic [31:0] address_reg_k = 0, data_reg_k = 0, index_reg = 0, pc_value = 0;
  logic [15:0] ext_word0 = 0, ext_word1 = 0;
  logic [7:0] quick_data = 0, bcd_byte = 0;
  wire done, mem_access, operand_valid, areg_write, bcd_error;
  wire [31:0] effective_address, operand, areg_new;
  wire [1:0] ext_words_used;
  wire [5:0] op_width;
  wire [7:0] bcd_digits;
  wire [15:0] status_reg;
  wire [31:0] user_stack_ptr, supervisor_stack_ptr, vector_base;
  wire [2:0] source_function_code, dest_function_code;
  bit [31:0] seed = 32'he5304f83;
  bit [31:0] e_ea, e_op, e_new, e_dig;
  int e_mem, e_ov, e_aw, e_done, e_ext, e_w, e_err, mismatches, comparisons;
  bit te, ce;
  eag_unit dut_u (
    .clock(clock), .reset(reset), .clock_en(clock_en), .req_valid(req_valid),
    .mode(mode), .op_size(op_size), .reg_num(reg_num),
    .address_reg_k(address_reg_k), .data_reg_k(data_reg_k),
    .index_reg(index_reg), .index_long(index_long),
    .ext_word0(ext_word0), .ext_word1(ext_word1), .pc_value(pc_value),
    .quick_data(quick_data), .implied_sel(implied_sel), .status_reg(status_reg),
    .user_stack_ptr(user_stack_ptr), .supervisor_stack_ptr(supervisor_stack_ptr),
    .vector_base(vector_base), .source_function_code(source_function_code),
    .dest_function_code(dest_function_code), .bcd_packed(bcd_packed), .bcd_byte(bcd_byte),
    .done(done), .effective_address(effective_address), .mem_access(mem_access),
    .operand(operand), .operand_valid(operand_valid), .areg_write(areg_write),
    .areg_new(areg_new), .ext_words_used(ext_words_used), .op_width(op_width),
    .bcd_digits(bcd_digits), .bcd_error(bcd_error)
  );
  eag_sysregs sys_u (
    .status_reg(status_reg),
    .user_stack_ptr(user_stack_ptr),
    .supervisor_stack_ptr(supervisor_stack_ptr),
    .vector_base(vector_base),
    .source_function_code(source_function_code),
    .dest_function_code(dest_function_code)
  );
  initial forever #2 clock = ~clock;
  initial begin
    #20000;
    mismatches++;
    print_verdict;
  end
  function automatic bit [31:0] rnd();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction
  function automatic bit [31:0] sx(bit [15:0] v, bit b8);
    return b8 ? {{24{v[7]}}, v[7:0]} : {{16{v[15]}}, v};
  endfunction
  task automatic chk(string n, logic [31:0] e, logic [31:0] g);
    comparisons++;
    if (g !== e) begin
      mismatches++;
      $display("mismatch %s exp %h got %h", n, e, g);
    end
  endtask
  task automatic print_verdict;
    if (mismatches == 0 && comparisons > 0) $display("verification passed");
    else $display("verification failed");
    $finish;
  endtask
  // ***
  // reference model, run on every taken request
  // ***
  task automatic model;
    bit [31:0] a, x, s;
    a = address_reg_k;
    x = index_long ? index_reg : sx(index_reg[15:0], 0);
    s = op_size == 0 ? (reg_num == 7 ? 2 : 1) : op_size == 1 ? 2 : op_size == 2 ? 4 : 1;
    e_new = mode == 3 ? a + s : mode == 4 ? a - s : a;
    e_ea = 0;
    e_op = 0;
    case (mode)
      0: e_op = data_reg_k;
      1: e_op = a;
      2, 3: e_ea = a;
      4: e_ea = a - s;
      5: e_ea = a + sx(ext_word0, 0);
      6: e_ea = a + x + sx(ext_word0, 1);
      7: e_ea = sx(ext_word0, 0);
      8: e_ea = {ext_word0, ext_word1};
      9: e_ea = pc_value + sx(ext_word0, 0);
      10: e_ea = pc_value + x + sx(ext_word0, 1);
      11: e_op = op_size == 2 ? {ext_word0, ext_word1} : op_size == 1 ? ext_word0 : ext_word0[7:0];
      12: e_op = sx(quick_data, 1);
      default: case (implied_sel)
        0: e_op = status_reg;
        1: e_op = user_stack_ptr;
        2: e_op = supervisor_stack_ptr;
        3: e_op = pc_value;
        4: e_op = vector_base;
        5: e_op = source_function_code;
        6: e_op = dest_function_code;
        default: e_op = 0;
      endcase
    endcase
    e_ext = mode == 8 || (mode == 11 && op_size == 2) ? 2 : (mode > 4 && mode < 12 && mode != 8) ? 1 : 0;
    e_ov = mode < 2 || mode > 10;
    e_mem = !e_ov;
    e_aw = mode == 3 || mode == 4;
    e_w = op_size == 0 ? 8 : op_size == 1 ? 16 : op_size == 2 ? 32 : 1;
    e_dig = bcd_packed ? bcd_byte : bcd_byte[3:0];
    e_err = bcd_byte[3:0] > 9 || (bcd_packed && bcd_byte[7:4] > 9);
  endtask
  initial begin
    repeat (10) @(posedge clock);
    #1 reset = 0;
    for (int i = 0; i < 3000; i++) begin
      @(posedge clock);
      #1;
      e_done = te ? 1 : ce ? 0 : e_done;
      chk("done", e_done, done);
      chk("areg_write", e_done & e_aw, areg_write);
      chk("ea", e_ea, effective_address);
      chk("mem", e_mem, mem_access);
      chk("operand", e_op, operand);
      chk("opvalid", e_ov, operand_valid);
      chk("ext", e_ext, ext_words_used);
      chk("width", e_w, op_width);
      chk("bcd", e_dig, bcd_digits);
      chk("bcd_err", e_err, bcd_error);
      chk("areg_new", e_new, areg_new);
      ce = rnd() % 8 != 0;
      clock_en = ce;
      req_valid = rnd() % 4 != 0;
      te = ce && req_valid;
      mode = 4'(rnd() % 14);
      op_size = 2'(rnd());
      if (mode == 11 && op_size == 3) op_size = 2;
      reg_num = 3'(rnd());
      address_reg_k = rnd();
      data_reg_k = rnd();
      index_reg = rnd();
      index_long = 1'(rnd());
      {ext_word0, ext_word1} = rnd();
      pc_value = rnd();
      {quick_data, bcd_byte, implied_sel, bcd_packed} = 20'(rnd());
      if (te) model;
    end
    print_verdict;
  end
endmodule // eag_unit_test
`default_nettype wire
